// *** verilog/qac_top.v ***
// Serial configuration port, register bank, clock control and output datapath
`timescale 1ns/1ns
`include "qac_regs.vh"

module qac_top #(
	parameter       NCH     = 4,
	parameter       DW      = 14,
	parameter [7:0] PART_ID = 8'h5A,  // Arbitrary identity value
	parameter [2:0] SPEED   = 3'h6
) (
	// Clock and reset
	input  wire              i_clock,
	input  wire              i_rst,
	// Three-wire serial port
	input  wire              i_spi_sclk,
	input  wire              i_spi_cs_n,
	input  wire              i_sdio_in,
	output reg               o_sdio_out,
	output wire              o_sdio_oe_n,
	// Pins
	input  wire              i_power_save_pin,
	input  wire              i_sync,
	input  wire [NCH*DW-1:0] i_adc_data,
	// Power, clock and framing status
	output wire              o_duty_cycle_stabiliser,
	output reg               o_relocking,
	output wire              o_ref_off,
	output wire              o_bias_off,
	output wire              o_clock_off,
	output wire              o_core_reset,
	output wire              o_out_hiz,
	output reg               o_sample_strobe,
	output wire [2:0]        o_framing_mode,
	output wire              o_framing_lsb_first,
	output wire [5:0]        o_clock_out_sel,
	// Channel data
	output reg  [NCH*DW-1:0] o_chan_data,
	output reg               o_chan_valid
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [2:0]  spicfg_q;  // {lsb_first, soft_reset, addr16}
	reg  [7:0]  chsel_q, pwr_q, stab_q, div_q, chop_q, fmt_q, drv_q;
	reg  [7:0]  phase_q, fs_q, p1l_q, p1h_q, p2l_q, p2h_q, fram_q;
	reg  [7:0]  rate_q, pull_q, cm_q, thr_q, sync_q;
	reg  [7:0]  tm_q  [0:NCH-1];
	reg  [7:0]  ofs_q [0:NCH-1];
	reg  [7:0]  lane_q[0:NCH-1];
	reg  [2:0]  div_act_q, phase_act_q;
	reg  [7:0]  fram_act_q;
	reg         commit_q;
	integer     k;
	integer     j;
	localparam [7:0]   PHASE_RST = `QAC_R_PHASE;
	localparam integer RELOCK_N  = `QAC_RELOCK_CYC;

	// ----------------------------------------
	// Serial port
	// ----------------------------------------
	reg         sclk_q;
	reg  [5:0]  bit_q;
	reg  [15:0] instr_q;
	reg  [7:0]  sh_q;
	reg  [12:0] addr_q;
	reg         wr_q;
	reg  [7:0]  rd_data;
	reg         drive_q;
	wire        rise = i_spi_sclk & ~sclk_q;
	wire        fall = ~i_spi_sclk & sclk_q;
	wire        active = ~i_spi_cs_n;
	wire [15:0] instr_d = {instr_q[14:0], i_sdio_in};
	wire [7:0]  sh_d = {sh_q[6:0], i_sdio_in};
	wire [7:0]  wbyte = spicfg_q[2] ?
		{sh_d[0], sh_d[1], sh_d[2], sh_d[3],
		sh_d[4], sh_d[5], sh_d[6], sh_d[7]} : sh_d;
	wire        byte_end = active & rise & (bit_q[5:4] != 2'h0) &
		(bit_q[2:0] == 3'h7);
	wire        wr_stb = byte_end & ~wr_q;
	wire        soft_rst = spicfg_q[1];

	assign o_sdio_oe_n = ~drive_q;

	always @(posedge i_clock) begin
		sclk_q <= i_spi_sclk;
		if (i_rst | ~active) begin
			bit_q   <= 6'h00;
			drive_q <= 1'b0;
			wr_q    <= 1'b0;
			addr_q  <= 13'h0000;
			instr_q <= 16'h0000;
			sh_q    <= 8'h00;
			o_sdio_out <= 1'b0;
		end else begin
			if (rise) begin
				if (bit_q < 6'h10) begin
					instr_q <= instr_d;
				end else if (~wr_q) begin
					sh_q <= sh_d;
				end
				if (bit_q == 6'h0F) begin
					wr_q   <= instr_d[15];
					addr_q <= instr_d[12:0];
					sh_q   <= 8'h00;
				end
				if (byte_end) begin
					addr_q <= addr_q + 13'h0001;
				end
				bit_q <= (bit_q == 6'h17) ? 6'h10 : bit_q + 6'h01;
			end
			if (fall & wr_q & (bit_q >= 6'h10)) begin
				drive_q <= 1'b1;
				sh_q <= (bit_q == 6'h10) ? {rd_data[6:0], 1'b0} :
					{sh_q[6:0], 1'b0};
				o_sdio_out <= (bit_q == 6'h10) ?
					(spicfg_q[2] ? rd_data[0] : rd_data[7]) :
					sh_q[7];
				if (bit_q == 6'h10 && spicfg_q[2]) begin
					sh_q <= {rd_data[1], rd_data[2], rd_data[3],
						rd_data[4], rd_data[5], rd_data[6],
						rd_data[7], 1'b0};
				end
			end
		end
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	reg [1:0] rch;
	always @* begin
		rch = 2'h0;
		for (j = NCH - 1; j >= 0; j = j - 1) begin
			if (chsel_q[j]) begin
				rch = j[1:0];
			end
		end
		case (addr_q)
		`QAC_A_SPI_CFG:  rd_data = {1'b0, spicfg_q[2], spicfg_q[1],
			spicfg_q[0], spicfg_q[0], spicfg_q[1], spicfg_q[2],
			1'b0};
		`QAC_A_PART_ID:  rd_data = PART_ID;
		`QAC_A_SPEED:    rd_data = {1'b0, SPEED, 4'h0};
		`QAC_A_CH_SEL:   rd_data = chsel_q;
		`QAC_A_PWR_MODE: rd_data = pwr_q;
		`QAC_A_CLK_STAB: rd_data = stab_q;
		`QAC_A_CLK_DIV:  rd_data = div_q;
		`QAC_A_CHOP:     rd_data = chop_q;
		`QAC_A_TEST:     rd_data = tm_q[rch];
		`QAC_A_OFFSET:   rd_data = ofs_q[rch];
		`QAC_A_OUT_FMT:  rd_data = fmt_q;
		`QAC_A_OUT_DRV:  rd_data = drv_q;
		`QAC_A_PHASE:    rd_data = phase_q;
		`QAC_A_FS_SEL:   rd_data = fs_q;
		`QAC_A_PAT1_LO:  rd_data = p1l_q;
		`QAC_A_PAT1_HI:  rd_data = p1h_q;
		`QAC_A_PAT2_LO:  rd_data = p2l_q;
		`QAC_A_PAT2_HI:  rd_data = p2h_q;
		`QAC_A_FRAMING:  rd_data = fram_q;
		`QAC_A_LANE:     rd_data = lane_q[rch];
		`QAC_A_RATE:     rd_data = rate_q;
		`QAC_A_PULLDN:   rd_data = pull_q;
		`QAC_A_CM_PWR:   rd_data = cm_q;
		`QAC_A_THRESH:   rd_data = thr_q;
		`QAC_A_SYNC:     rd_data = sync_q;
		default:         rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Register writes, staging and soft reset
	// ----------------------------------------
	always @(posedge i_clock) begin
		commit_q <= wr_stb & (addr_q == `QAC_A_COMMIT) & wbyte[0];
		if (i_rst | soft_rst) begin
			spicfg_q <= 3'h1;
			chsel_q <= `QAC_R_CH_SEL;
			pwr_q   <= `QAC_R_ZERO;
			stab_q  <= `QAC_R_CLK_STAB;
			div_q   <= `QAC_R_ZERO;
			chop_q  <= `QAC_R_ZERO;
			fmt_q   <= `QAC_R_OUT_FMT;
			drv_q   <= `QAC_R_ZERO;
			phase_q <= `QAC_R_PHASE;
			fs_q    <= `QAC_R_ZERO;
			p1l_q   <= `QAC_R_ZERO;
			p1h_q   <= `QAC_R_ZERO;
			p2l_q   <= `QAC_R_ZERO;
			p2h_q   <= `QAC_R_ZERO;
			fram_q  <= `QAC_R_FRAMING;
			rate_q  <= `QAC_R_ZERO;
			pull_q  <= `QAC_R_ZERO;
			cm_q    <= `QAC_R_ZERO;
			thr_q   <= `QAC_R_ZERO;
			sync_q  <= `QAC_R_ZERO;
			div_act_q   <= 3'h0;
			phase_act_q <= PHASE_RST[6:4];
			fram_act_q  <= `QAC_R_FRAMING;
			for (k = 0; k < NCH; k = k + 1) begin
				tm_q[k]   <= `QAC_R_ZERO;
				ofs_q[k]  <= `QAC_R_ZERO;
				lane_q[k] <= `QAC_R_ZERO;
			end
		end else begin
			if (commit_q) begin
				div_act_q   <= div_q[2:0];
				phase_act_q <= phase_q[6:4];
				fram_act_q  <= fram_q;
			end
			if (wr_stb) begin
				case (addr_q)
				`QAC_A_SPI_CFG:  spicfg_q <= {wbyte[6] | wbyte[1],
					wbyte[5] | wbyte[2], wbyte[4] | wbyte[3]};
				`QAC_A_CH_SEL:   chsel_q <= {2'h0, wbyte[5:0]};
				`QAC_A_PWR_MODE: pwr_q   <= wbyte;
				`QAC_A_CLK_STAB: stab_q  <= wbyte;
				`QAC_A_CLK_DIV:  div_q   <= wbyte;
				`QAC_A_CHOP:     chop_q  <= wbyte;
				`QAC_A_OUT_FMT:  fmt_q   <= wbyte;
				`QAC_A_OUT_DRV:  drv_q   <= wbyte;
				`QAC_A_PHASE:    phase_q <= wbyte;
				`QAC_A_FS_SEL:   fs_q    <= wbyte;
				`QAC_A_PAT1_LO:  p1l_q   <= wbyte;
				`QAC_A_PAT1_HI:  p1h_q   <= wbyte;
				`QAC_A_PAT2_LO:  p2l_q   <= wbyte;
				`QAC_A_PAT2_HI:  p2h_q   <= wbyte;
				`QAC_A_FRAMING:  fram_q  <= wbyte;
				`QAC_A_RATE:     rate_q  <= wbyte;
				`QAC_A_PULLDN:   pull_q  <= wbyte;
				`QAC_A_CM_PWR:   cm_q    <= wbyte;
				`QAC_A_THRESH:   thr_q   <= wbyte;
				`QAC_A_SYNC:     sync_q  <= wbyte;
				default:         ;
				endcase
				for (k = 0; k < NCH; k = k + 1) begin
					if (chsel_q[k]) begin
						if (addr_q == `QAC_A_TEST) tm_q[k] <= wbyte;
						if (addr_q == `QAC_A_OFFSET) ofs_q[k] <= wbyte;
						if (addr_q == `QAC_A_LANE) lane_q[k] <= wbyte;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Power modes
	// ----------------------------------------
	wire pin_full = i_power_save_pin & ~pwr_q[`QAC_B_PIN_STBY];
	wire pin_stby = i_power_save_pin & pwr_q[`QAC_B_PIN_STBY];
	wire full_pd = (pwr_q[1:0] == `QAC_PM_FULL) | pin_full;
	wire standby = (pwr_q[1:0] == `QAC_PM_STBY) | pin_stby;

	assign o_ref_off    = full_pd;
	assign o_bias_off   = full_pd | standby;
	assign o_clock_off  = full_pd | standby;
	assign o_core_reset = (pwr_q[1:0] == `QAC_PM_RESET);
	assign o_out_hiz    = full_pd | standby;
	assign o_duty_cycle_stabiliser = ~stab_q[0];
	assign o_framing_mode      = fram_act_q[6:4];
	assign o_framing_lsb_first = fram_act_q[7];
	assign o_clock_out_sel     = chsel_q[5:0];

	// ----------------------------------------
	// Relock window, divider, sync and phase
	// ----------------------------------------
	reg  [6:0] relock_q;
	reg  [2:0] dcnt_q;
	reg        sync_q1, sync_done_q;
	reg  [7:0] ph_q;
	wire       sync_edge = i_sync & ~sync_q1;
	wire       sync_ok = sync_edge & sync_q[`QAC_B_SYNC_EN] &
		~(sync_q[`QAC_B_SYNC_ONCE] & sync_done_q);
	wire       div_tick = (dcnt_q == div_act_q) & ~o_clock_off;

	always @(posedge i_clock) begin
		sync_q1 <= i_sync;
		if (i_rst | soft_rst) begin
			relock_q    <= 7'h00;
			o_relocking <= 1'b0;
			dcnt_q      <= 3'h0;
			sync_done_q <= 1'b0;
			ph_q        <= 8'h00;
			o_sample_strobe <= 1'b0;
		end else begin
			if (commit_q & (div_q[2:0] != div_act_q) & ~stab_q[0]) begin
				relock_q    <= RELOCK_N[6:0];
				o_relocking <= 1'b1;
			end else if (relock_q != 7'h00) begin
				relock_q    <= relock_q - 7'h01;
				o_relocking <= (relock_q != 7'h01);
			end
			if (sync_ok) begin
				sync_done_q <= 1'b1;
			end else if (wr_stb & (addr_q == `QAC_A_SYNC)) begin
				sync_done_q <= 1'b0;
			end
			if (sync_ok) begin
				dcnt_q <= 3'h0;
			end else if (div_tick | (dcnt_q > div_act_q)) begin
				dcnt_q <= 3'h0;
			end else begin
				dcnt_q <= dcnt_q + 3'h1;
			end
			ph_q <= {ph_q[6:0], div_tick & ~sync_ok};
			o_sample_strobe <= (phase_act_q == 3'h0) ?
				(div_tick & ~sync_ok) : ph_q[phase_act_q - 3'h1];
		end
	end

	// ----------------------------------------
	// Per-channel output datapath
	// ----------------------------------------
	wire [15:0] pat1 = {p1h_q, p1l_q};
	wire [15:0] pat2 = {p2h_q, p2l_q};

	always @(posedge i_clock) begin
		if (i_rst) begin
			o_chan_valid <= 1'b0;
		end else begin
			o_chan_valid <= o_sample_strobe & ~o_out_hiz;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			reg  [8:0]    pns_q;
			reg  [22:0]   pnl_q;
			reg           tgl_q;
			reg  [1:0]    ucnt_q;
			reg  [DW-1:0] pat;
			wire [3:0]    tmode = tm_q[g][3:0];
			wire [1:0]    umode = tm_q[g][7:6];
			wire [DW:0]   sum = {1'b0, i_adc_data[g*DW +: DW]} +
				{{(DW-7){ofs_q[g][7]}}, ofs_q[g]};
			wire [DW-1:0] trim = (ofs_q[g][7] & sum[DW]) ?
				{DW{1'b0}} : (~ofs_q[g][7] & sum[DW]) ?
				{DW{1'b1}} : sum[DW-1:0];
			wire [DW-1:0] conv = fmt_q[0] ?
				{~trim[DW-1], trim[DW-2:0]} : trim;
			wire          ustop = umode[1] & (ucnt_q == 2'h3);
			wire [DW-1:0] usel = (umode[0] & tgl_q) ?
				pat2[15:16-DW] : pat1[15:16-DW];

			always @* begin
				case (tmode)
				`QAC_TM_OFF:     pat = conv;
				`QAC_TM_MID:     pat = {1'b1, {(DW-1){1'b0}}};
				`QAC_TM_POSFS:   pat = {DW{1'b1}};
				`QAC_TM_NEGFS:   pat = {DW{1'b0}};
				`QAC_TM_CHECK:   pat = tgl_q ? {(DW/2){2'h2}} :
					{(DW/2){2'h1}};
				`QAC_TM_PNLONG:  pat = pnl_q[DW-1:0];
				`QAC_TM_PNSHORT: pat = {pns_q, pns_q[DW-10:0]};
				`QAC_TM_WORDTGL: pat = {DW{tgl_q}};
				`QAC_TM_USER:    pat = ustop ? {DW{1'b0}} : usel;
				`QAC_TM_BITTGL:  pat = tgl_q ? {(DW/2){2'h2}} :
					{(DW/2){2'h1}};
				`QAC_TM_SYNC:    pat = {{(DW/2){1'b1}}, {(DW/2){1'b0}}};
				`QAC_TM_ONEBIT:  pat = {1'b1, {(DW-1){1'b0}}};
				default:         pat = conv;
				endcase
			end

			always @(posedge i_clock) begin
				if (i_rst | tm_q[g][`QAC_B_PN_SHORT]) begin
					pns_q <= 9'h1FF;
				end else if (o_sample_strobe) begin
					pns_q <= {pns_q[7:0], pns_q[8] ^ pns_q[4]};
				end
				if (i_rst | tm_q[g][`QAC_B_PN_LONG]) begin
					pnl_q <= 23'h7FFFFF;
				end else if (o_sample_strobe) begin
					pnl_q <= {pnl_q[21:0], pnl_q[22] ^ pnl_q[17]};
				end
				if (i_rst | (wr_stb & (addr_q == `QAC_A_TEST))) begin
					tgl_q  <= 1'b0;
					ucnt_q <= 2'h0;
				end else if (o_sample_strobe) begin
					tgl_q <= ~tgl_q;
					if (umode[1] & (ucnt_q != 2'h3) &
						(~umode[0] | tgl_q)) begin
						ucnt_q <= 2'h3;
					end
				end
				if (i_rst) begin
					o_chan_data[g*DW +: DW] <= {DW{1'b0}};
				end else if (o_out_hiz | (|lane_q[g][1:0])) begin
					o_chan_data[g*DW +: DW] <= {DW{1'b0}};
				end else if (o_sample_strobe) begin
					o_chan_data[g*DW +: DW] <= pat;
				end
			end
		end
	endgenerate

endmodule // qac_top

// *** verilog/qac_regs.vh ***
// Register offsets, reset values and timing constants of the converter control
// Operation
// - Stabiliser on regenerates the falling edge for a 50% internal clock.
// - After a clock rate change the loop relocks within 1.5 to 5 us.
// - Power saving is entered by register command or by the pin high.
// - In power saving the data output drivers go high impedance.
// - Pin returning low leaves power saving and resumes conversion.
// - Full power-down stops reference, buffer, bias, clock; standby keeps reference.
// - Configuration uses three-wire serial port with one bidirectional data line.
// - Port config holds soft reset, LSB-first, 16-bit address, mirrored, reset 0x18.
// - Channel select picks channels and clock outputs for local writes; resets 0x3F.
// - Writing one to transfer bit 0 commits staged writes into operation.
// - Power mode bits 1:0: normal, full power-down, standby, reset.
// - A bit chooses pin action: zero full power-down, one standby.
// - Clock register bit 0 zero turns stabiliser on; reset value 0x01.
// - Three-bit divider field divides input clock by field plus one.
// - Four-bit test mode replaces conversion data with a selected pattern.
// - User pattern sub-mode: repeat, alternate, once, or alternate once.
// - Separate bits hold long and short pseudo-random generators in reset.
// - Offset trim adds signed -128..+127 LSB to each selected channel.
// - Output mode bit 0 picks offset binary or two's complement; reset 0x01.
// - Phase bits 6:4 delay sampling by that many input clocks; reset 0x03.
// - Framing bits 6:4 pick lane mode, bit 7 LSB first; reset 0x30.
// - Sync register: bit 0 enables divider sync, bit 1 next pulse only.
// - Each accepted sync returns the divider to its initial count.
`ifndef QAC_REGS_VH
`define QAC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define QAC_A_SPI_CFG   13'h0000
`define QAC_A_PART_ID   13'h0001
`define QAC_A_SPEED     13'h0002
`define QAC_A_CH_SEL    13'h0005
`define QAC_A_PWR_MODE  13'h0008
`define QAC_A_CLK_STAB  13'h0009
`define QAC_A_CLK_DIV   13'h000B
`define QAC_A_CHOP      13'h000C
`define QAC_A_TEST      13'h000D
`define QAC_A_OFFSET    13'h0010
`define QAC_A_OUT_FMT   13'h0014
`define QAC_A_OUT_DRV   13'h0015
`define QAC_A_PHASE     13'h0016
`define QAC_A_FS_SEL    13'h0018
`define QAC_A_PAT1_LO   13'h0019
`define QAC_A_PAT1_HI   13'h001A
`define QAC_A_PAT2_LO   13'h001B
`define QAC_A_PAT2_HI   13'h001C
`define QAC_A_FRAMING   13'h0021
`define QAC_A_LANE      13'h0022
`define QAC_A_COMMIT    13'h00FF
`define QAC_A_RATE      13'h0100
`define QAC_A_PULLDN    13'h0101
`define QAC_A_CM_PWR    13'h0102
`define QAC_A_THRESH    13'h0106
`define QAC_A_SYNC      13'h0109

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QAC_R_SPI_CFG   8'h18
`define QAC_R_CH_SEL    8'h3F
`define QAC_R_CLK_STAB  8'h01
`define QAC_R_OUT_FMT   8'h01
`define QAC_R_PHASE     8'h03
`define QAC_R_FRAMING   8'h30
`define QAC_R_ZERO      8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define QAC_B_PIN_STBY  5
`define QAC_B_PN_LONG   5
`define QAC_B_PN_SHORT  4
`define QAC_B_SYNC_EN   0
`define QAC_B_SYNC_ONCE 1

// ----------------------------------------
// Power modes and test modes
// ----------------------------------------
`define QAC_PM_NORMAL   2'h0
`define QAC_PM_FULL     2'h1
`define QAC_PM_STBY     2'h2
`define QAC_PM_RESET    2'h3
`define QAC_TM_OFF      4'h0
`define QAC_TM_MID      4'h1
`define QAC_TM_POSFS    4'h2
`define QAC_TM_NEGFS    4'h3
`define QAC_TM_CHECK    4'h4
`define QAC_TM_PNLONG   4'h5
`define QAC_TM_PNSHORT  4'h6
`define QAC_TM_WORDTGL  4'h7
`define QAC_TM_USER     4'h8
`define QAC_TM_BITTGL   4'h9
`define QAC_TM_SYNC     4'hA
`define QAC_TM_ONEBIT   4'hB

// ----------------------------------------
// Timing
// ----------------------------------------
`define QAC_CLK_NS      100
`define QAC_RELOCK_NS   5000
`define QAC_RELOCK_CYC  ((`QAC_RELOCK_NS + `QAC_CLK_NS - 1) / `QAC_CLK_NS)

`endif

// *** sim/qac_spi_host.sv ***
// Host model driving the three-wire configuration port
`timescale 1ns/1ns
module qac_spi_host (
	// Clock and port pins
	input  wire i_clock,
	input  wire i_sdio_out,
	input  wire i_sdio_oe_n,
	output reg  o_sclk,
	output reg  o_cs_n,
	output wire o_sdio_line
);
	reg drive_bit;
	reg lsb_first;
	// Device value when it drives, else host value or inverted last value
	assign o_sdio_line = !i_sdio_oe_n ? i_sdio_out : drive_bit;
	initial begin
		o_sclk    = 1'b0;
		o_cs_n    = 1'b1;
		drive_bit = 1'b0;
		lsb_first = 1'b0;
	end
	// One bit: low half sets data, line sampled before the rise
	task step(input b, input drv, output r);
	begin
		@(posedge i_clock);
		#1;
		o_sclk    = 1'b0;
		drive_bit = drv ? b : ~drive_bit;
		repeat (2) @(posedge i_clock);
		#1;
		r      = o_sdio_line;
		o_sclk = 1'b1;
		@(posedge i_clock);
	end
	endtask
	// Instruction word then one data byte
	task xfer(input rd, input [12:0] a, input [7:0] wd, output [7:0] rdat);
		integer   i;
		reg [15:0] cmd;
		reg [7:0]  d;
		reg        r;
	begin
		cmd = {rd, 2'b00, a};
		for (i = 0; i < 8; i = i + 1)
			d[i] = lsb_first ? wd[7 - i] : wd[i];
		@(posedge i_clock);
		#1;
		o_cs_n = 1'b0;
		for (i = 15; i >= 0; i = i - 1)
			step(cmd[i], 1'b1, r);
		for (i = 7; i >= 0; i = i - 1) begin
			step(d[i], !rd, r);
			rdat[i] = r;
		end
		@(posedge i_clock);
		#1;
		o_cs_n    = 1'b1;
		o_sclk    = 1'b0;
		drive_bit = ~drive_bit;
		d = rdat;
		for (i = 0; i < 8; i = i + 1)
			rdat[i] = lsb_first ? d[7 - i] : d[i];
	end
	endtask
endmodule // qac_spi_host

// *** sim/qac_top_properties.sv ***
// Port checks of the converter control block
`timescale 1ns/1ns
module qac_props #(
	parameter NCH = 4,
	parameter DW  = 14
) (
	// Watched ports
	input wire              i_clock,
	input wire              i_rst,
	input wire              i_spi_cs_n,
	input wire              i_power_save_pin,
	input wire              o_sdio_oe_n,
	input wire              o_duty_cycle_stabiliser,
	input wire              o_relocking,
	input wire              o_ref_off,
	input wire              o_bias_off,
	input wire              o_clock_off,
	input wire              o_out_hiz,
	input wire              o_sample_strobe,
	input wire [NCH*DW-1:0] o_chan_data,
	input wire              o_chan_valid
);
	reg [6:0] reloc_cnt_q;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Counts cycles of one relock interval
	always @(posedge i_clock) begin
		if (i_rst || !o_relocking)
			reloc_cnt_q <= 7'h00;
		else
			reloc_cnt_q <= reloc_cnt_q + 7'h01;
	end
	// ----
	// Properties
	// ----
	property p_pin_hiz;
		i_power_save_pin |-> o_out_hiz;
	endproperty
	a_pin_hiz: assert property (p_pin_hiz)
		else $error("pin high without hiz");
	property p_hiz_data;
		o_out_hiz |=> o_chan_data == 0 && !o_chan_valid;
	endproperty
	a_hiz_data: assert property (p_hiz_data)
		else $error("data out while hiz");
	property p_full_off;
		o_ref_off |-> o_bias_off && o_clock_off && o_out_hiz;
	endproperty
	a_full_off: assert property (p_full_off)
		else $error("partial full power-down");
	property p_valid;
		o_chan_valid |-> $past(o_sample_strobe);
	endproperty
	a_valid: assert property (p_valid)
		else $error("valid without strobe");
	property p_relock_max;
		o_relocking |-> reloc_cnt_q < 7'd50;
	endproperty
	a_relock_max: assert property (p_relock_max)
		else $error("relock too long");
	property p_relock_len;
		$fell(o_relocking) |-> reloc_cnt_q == 7'd50;
	endproperty
	a_relock_len: assert property (p_relock_len)
		else $error("relock wrong length");
	property p_relock_stab;
		$rose(o_relocking) |-> o_duty_cycle_stabiliser;
	endproperty
	a_relock_stab: assert property (p_relock_stab)
		else $error("relock with stabiliser off");
	property p_oe;
		i_spi_cs_n |=> o_sdio_oe_n;
	endproperty
	a_oe: assert property (p_oe)
		else $error("data line driven while deselected");
endmodule // qac_props

bind qac_top qac_props #(
	.NCH(NCH),
	.DW (DW)
) u_props (
	.i_clock(i_clock),
	.i_rst(i_rst),
	.i_spi_cs_n(i_spi_cs_n),
	.i_power_save_pin(i_power_save_pin),
	.o_sdio_oe_n(o_sdio_oe_n),
	.o_duty_cycle_stabiliser(o_duty_cycle_stabiliser),
	.o_relocking(o_relocking),
	.o_ref_off(o_ref_off),
	.o_bias_off(o_bias_off),
	.o_clock_off(o_clock_off),
	.o_out_hiz(o_out_hiz),
	.o_sample_strobe(o_sample_strobe),
	.o_chan_data(o_chan_data),
	.o_chan_valid(o_chan_valid)
);

// *** sim/quad_adc_config_control_test.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/1ns
module quad_adc_config_control_test;
	localparam [7:0] PART = 8'hC3; // Arbitrary identity value
	reg         clock;
	reg         rst;
	reg         pin;
	reg         sync;
	reg  [55:0] adc;
	wire        sclk;
	wire        cs_n;
	wire        line;
	wire        sdo;
	wire        oe_n;
	wire        duty_cycle_stabiliser;
	wire        reloc;
	wire [4:0]  pwr;
	wire        strobe;
	wire [2:0]  fmode;
	wire        lsbf;
	wire [5:0]  csel;
	wire [55:0] cdata;
	wire        valid;
	integer     num_errors;
	integer     n_compared;
	qac_spi_host u_host (.i_clock(clock), .i_sdio_out(sdo),
		.i_sdio_oe_n(oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio_line(line));
	qac_top #(.PART_ID(PART)) dut (.i_clock(clock), .i_rst(rst),
		.i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_sdio_in(line),
		.o_sdio_out(sdo), .o_sdio_oe_n(oe_n), .i_power_save_pin(pin),
		.i_sync(sync), .i_adc_data(adc), .o_duty_cycle_stabiliser(duty_cycle_stabiliser),
		.o_relocking(reloc), .o_ref_off(pwr[4]), .o_bias_off(pwr[3]),
		.o_clock_off(pwr[2]), .o_core_reset(pwr[1]), .o_out_hiz(pwr[0]),
		.o_sample_strobe(strobe), .o_framing_mode(fmode),
		.o_framing_lsb_first(lsbf), .o_clock_out_sel(csel),
		.o_chan_data(cdata), .o_chan_valid(valid));
	task give_verdict;
	begin
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task check(input [63:0] seen, input [63:0] exp, input [95:0] what);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("wrong value %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task tick(input integer n);
	begin
		repeat (n) @(posedge clock);
		#1;
	end
	endtask
	task wr(input [12:0] a, input [7:0] d);
		reg [7:0] junk;
	begin
		u_host.xfer(1'b0, a, d, junk);
	end
	endtask
	task rd(input [12:0] a, input [7:0] exp);
		reg [7:0] v;
	begin
		u_host.xfer(1'b1, a, 8'h00, v);
		check(v, exp, "register");
	end
	endtask
	task count(input integer c, output integer n);
		integer k;
	begin
		n = 0;
		for (k = 0; k < c; k = k + 1) begin
			tick(1);
			n = n + strobe;
		end
	end
	endtask
	task commit_wait;
		integer k;
	begin
		wr(13'h0FF, 8'h01);
		tick(3);
		k = 0;
		while (reloc !== 1'b0 && k < 60) begin
			tick(1);
			k = k + 1;
		end
		check(reloc, 1'b0, "relock end");
		if (k >= 60)
			give_verdict;
	end
	endtask
	function [4:0] pm(input integer m);
	begin
		pm = (m == 1) ? 5'h1D : (m == 2) ? 5'h0D : (m == 3) ? 5'h02 : 5'h00;
	end
	endfunction
	// ----
	// Scenarios
	// ----
	task t_reset;
	begin
		rd(13'h000, 8'h18);
		rd(13'h005, 8'h3F);
		rd(13'h009, 8'h01);
		rd(13'h014, 8'h01);
		rd(13'h016, 8'h03);
		rd(13'h021, 8'h30);
		check({duty_cycle_stabiliser, fmode, csel}, 10'h0FF, "reset pins");
		wr(13'h001, 8'h00);
		rd(13'h001, PART);
		rd(13'h003, 8'h00);
	end
	endtask
	task t_power;
		integer m;
	begin
		for (m = 0; m < 4; m = m + 1) begin
			wr(13'h008, m[7:0]);
			check(pwr, pm(m), "power mode");
		end
		wr(13'h008, 8'h00);
		pin = 1'b1;
		tick(2);
		check(pwr, pm(1), "pin down");
		pin = 1'b0;
		tick(2);
		check(pwr, 5'h00, "pin release");
		wr(13'h008, 8'h20);
		pin = 1'b1;
		tick(2);
		check(pwr, pm(2), "pin standby");
		pin = 1'b0;
		wr(13'h008, 8'h00);
	end
	endtask
	task t_divider;
		integer n;
	begin
		wr(13'h009, 8'h00);
		check(duty_cycle_stabiliser, 1'b1, "stabiliser");
		wr(13'h00B, 8'h07);
		count(80, n);
		check(n, 80, "staged div");
		wr(13'h0FF, 8'h01);
		tick(3);
		check(reloc, 1'b1, "relocking");
		count(80, n);
		check(n, 10, "divide by 8");
		wr(13'h00B, 8'h00);
		commit_wait;
		wr(13'h021, 8'hC0);
		check(fmode, 3'h3, "staged frame");
		commit_wait;
		check({lsbf, fmode}, 4'hC, "framing");
	end
	endtask
	task t_data;
		reg [55:0] e;
	begin
		adc = {14'h2003, 14'h2002, 14'h2001, 14'h0000};
		wr(13'h014, 8'h00);
		tick(4);
		check(cdata, adc, "offset bin");
		check(valid, 1'b1, "chan valid");
		wr(13'h014, 8'h01);
		tick(4);
		e = {14'h0003, 14'h0002, 14'h0001, 14'h2000};
		check(cdata, e, "twos compl");
		wr(13'h005, 8'h01);
		wr(13'h010, 8'h05);
		wr(13'h005, 8'h02);
		check(csel, 6'h02, "clock sel");
		wr(13'h010, 8'hFF);
		rd(13'h010, 8'hFF);
		tick(4);
		e = {14'h0003, 14'h0002, 14'h0000, 14'h2005};
		check(cdata, e, "offset trim");
		wr(13'h010, 8'h00);
		wr(13'h005, 8'h01);
		wr(13'h010, 8'h00);
		wr(13'h005, 8'h3F);
	end
	endtask
	task t_pattern;
		integer    m;
		reg [55:0] e;
	begin
		wr(13'h014, 8'h00);
		for (m = 1; m < 4; m = m + 1) begin
			wr(13'h00D, m[7:0]);
			tick(4);
			e = (m == 1) ? {4{14'h2000}} : (m == 2) ? {4{14'h3FFF}} : 56'h0;
			check(cdata, e, "test mode");
		end
		wr(13'h019, 8'hCD);
		wr(13'h01A, 8'hAB);
		wr(13'h00D, 8'h08);
		tick(4);
		check(cdata, {4{14'h2AF3}}, "user patt");
		wr(13'h00D, 8'h88);
		tick(4);
		check(cdata, 56'h0, "patt once");
		wr(13'h00D, 8'h00);
		wr(13'h014, 8'h01);
	end
	endtask
	task sync_gap(output integer g);
	begin
		sync = 1'b1;
		tick(1);
		sync = 1'b0;
		tick(8);
		g = 0;
		while (strobe !== 1'b1 && g < 8) begin
			tick(1);
			g = g + 1;
		end
		if (g >= 8)
			check(strobe, 1'b1, "strobe wait");
		if (g >= 8)
			give_verdict;
	end
	endtask
	task t_sync;
		integer g0;
		integer g1;
	begin
		wr(13'h00B, 8'h03);
		commit_wait;
		wr(13'h109, 8'h01);
		sync_gap(g0);
		tick(5);
		sync_gap(g1);
		check(g1, g0, "sync gap");
		tick(6);
		sync_gap(g1);
		check(g1, g0, "sync gap");
		wr(13'h109, 8'h03);
		sync_gap(g1);
		check(g1, g0, "sync once");
		tick(5);
		sync_gap(g1);
		check(g1 != g0, 1'b1, "sync ignored");
		wr(13'h00B, 8'h00);
		commit_wait;
	end
	endtask
	task t_lsb_reset;
	begin
		wr(13'h000, 8'h5A);
		u_host.lsb_first = 1'b1;
		wr(13'h005, 8'h01);
		check(csel, 6'h01, "lsb first");
		rd(13'h005, 8'h01);
		wr(13'h000, 8'h24);
		u_host.lsb_first = 1'b0;
		tick(2);
		rd(13'h000, 8'h18);
		check({duty_cycle_stabiliser, csel}, 7'h3F, "soft reset");
	end
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		rst = 1'b1;
		pin = 1'b0;
		sync = 1'b0;
		adc = 56'h0;
		num_errors = 0;
		n_compared = 0;
		repeat (3) @(posedge clock);
		#1;
		rst = 1'b0;
		t_reset;
		t_power;
		t_divider;
		t_data;
		t_pattern;
		t_sync;
		t_lsb_reset;
		give_verdict;
	end
	initial begin
		#5000000;
		num_errors = num_errors + 1;
		give_verdict;
	end
endmodule // quad_adc_config_control_test
